// >>> verilog/rfs_regs.svh
`ifndef RFS_REGS_SVH
`define RFS_REGS_SVH

// ==========================================
// Register bus geometry
`define RFS_ADDR_W 12
`define RFS_DATA_W 8

// ==========================================
// Register offsets
`define RFS_CTRL_ADDR 12'h082
`define RFS_FMT_A_ADDR 12'h083
`define RFS_FMT_B_ADDR 12'h084
`define RFS_FMT_M_ADDR 12'h085
`define RFS_STATUS_ADDR 12'h086
`define RFS_IRQ_STAT_ADDR 12'h087
`define RFS_IRQ_MASK_ADDR 12'h088

// ==========================================
// Control register fields
`define RFS_CTRL_SOFT_SEL_BIT 0
`define RFS_CTRL_SOFT_EN_BIT 1
`define RFS_CTRL_AUTO_EN_BIT 2
`define RFS_CTRL_SYNTH_SRC_BIT 3
`define RFS_CTRL_RESET 8'h00

// ==========================================
// Status and interrupt fields
`define RFS_STAT_ACTIVE_BIT 0
`define RFS_STAT_SWITCHING_BIT 1
`define RFS_IRQ_START_BIT 0
`define RFS_IRQ_DONE_BIT 1
`define RFS_IRQ_W 2

// ==========================================
// Receiver format straps
`define RFS_FMT_W 2
`define RFS_NUM_RX 3
`define RFS_STRAP_W 7
`define RFS_STRAP_SYNTH_BIT 6

// ==========================================
// Switchover timing
`define RFS_CLK_PERIOD_NS 20
`define RFS_BREAK_NS 100
`define RFS_SETTLE_NS 200
`define RFS_BREAK_CYC ((`RFS_BREAK_NS + `RFS_CLK_PERIOD_NS - 1) / `RFS_CLK_PERIOD_NS)
`define RFS_SETTLE_CYC ((`RFS_SETTLE_NS + `RFS_CLK_PERIOD_NS - 1) / `RFS_CLK_PERIOD_NS)
`define RFS_CNT_W 4

`endif

// >>> verilog/rfs_pkg.sv
package rfs_pkg;

    typedef logic [1:0] rfs_fmt_t;

    typedef struct packed {
        logic synth_src;
        logic auto_en;
        logic soft_en;
        logic soft_sel;
    } rfs_ctrl_t;

    typedef struct packed {
        logic ref_a_lost;
        logic ref_b_lost;
    } rfs_mon_t;

    typedef struct packed {
        logic active;
        logic switching;
        logic start;
        logic done;
    } rfs_sw_stat_t;

    typedef enum logic [2:0] {
        RFS_IDLE = 3'b001,
        RFS_BREAK = 3'b010,
        RFS_SETTLE = 3'b100
    } rfs_sw_state_t;

endpackage

// >>> verilog/rfs_switch_seq.sv
`timescale 1ns/1ns
`include "rfs_regs.svh"

module rfs_switch_seq
    import rfs_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Selection request
    input wire logic want_sel,
    // Reference inputs
    input wire logic reference_input_a,
    input wire logic reference_input_b,
    // Mux output and status
    output logic selected_reference,
    output rfs_sw_stat_t stat
);

    // ==========================================
    // Switchover sequencer
    rfs_sw_state_t state;
    rfs_sw_state_t next_state;
    logic cur_sel;
    logic next_cur_sel;
    logic [`RFS_CNT_W-1:0] cnt;
    logic [`RFS_CNT_W-1:0] next_cnt;
    logic next_start;
    logic next_done;
    logic start_q;
    logic done_q;

    always_comb begin
        next_state = state;
        next_cur_sel = cur_sel;
        next_cnt = cnt;
        next_start = 1'b0;
        next_done = 1'b0;
        unique case (state)
            RFS_IDLE: begin
                if (want_sel != cur_sel) begin
                    next_state = RFS_BREAK;
                    next_cnt = `RFS_CNT_W'(`RFS_BREAK_CYC - 1);
                    next_start = 1'b1;
                end
            end
            RFS_BREAK: begin
                if (cnt == '0) begin
                    // Swap while the output is held low
                    next_cur_sel = want_sel;
                    next_state = RFS_SETTLE;
                    next_cnt = `RFS_CNT_W'(`RFS_SETTLE_CYC - 1);
                end else begin
                    next_cnt = cnt - 1'b1;
                end
            end
            RFS_SETTLE: begin
                if (cnt == '0) begin
                    next_state = RFS_IDLE;
                    next_done = 1'b1;
                end else begin
                    next_cnt = cnt - 1'b1;
                end
            end
            default: begin
                next_state = RFS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state <= RFS_IDLE;
            cur_sel <= 1'b0;
            cnt <= '0;
            start_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            state <= next_state;
            cur_sel <= next_cur_sel;
            cnt <= next_cnt;
            start_q <= next_start;
            done_q <= next_done;
        end
    end

    // ==========================================
    // Mux output
    logic next_selected;

    always_comb begin
        if (state == RFS_BREAK) begin
            next_selected = 1'b0;
        end else if (cur_sel) begin
            next_selected = reference_input_b;
        end else begin
            next_selected = reference_input_a;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            selected_reference <= 1'b0;
        end else begin
            selected_reference <= next_selected;
        end
    end

    assign stat.active = cur_sel;
    assign stat.switching = (state != RFS_IDLE);
    assign stat.start = start_q;
    assign stat.done = done_q;

endmodule

// >>> verilog/rfs_ref_select.sv
`timescale 1ns/1ns
`include "rfs_regs.svh"

// What this block does
// - Select pin low routes reference a, high routes reference b.
// - Select pin obeyed only while auto and soft select enables are both zero.
// - Active reference indicator low for reference a, high for reference b.
// - Switchover indicator high during a reference switch, low otherwise.
// - Receiver formats strapped at power-up, each rewritable independently by software.
// - Monitor reference feeds the reference monitor, and the integer synthesizer loop while the synth source bit is zero.

module rfs_ref_select
    import rfs_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Register port
    input wire logic [`RFS_ADDR_W-1:0] addr,
    input wire logic [`RFS_DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [`RFS_DATA_W-1:0] rdata,
    // Serial chip select
    input wire logic serial_cs_n,
    // Reference inputs
    input wire logic reference_input_a,
    input wire logic reference_input_b,
    input wire logic monitor_reference_input,
    input wire logic reference_select,
    // Monitor fault flags
    input wire rfs_mon_t mon,
    // Power-up straps
    input wire logic [`RFS_STRAP_W-1:0] strap_reader_first,
    // Clock outputs
    output logic selected_reference,
    output logic monitor_reference_out,
    output logic integer_synth_loop_ref,
    // Status outputs
    output logic active_reference_indicator,
    output logic switchover_in_progress,
    output rfs_fmt_t [`RFS_NUM_RX-1:0] receiver_format,
    // Interrupt
    output logic irq
);

    // ==========================================
    // Access qualification
    logic acc_wr;
    logic acc_rd;

    assign acc_wr = wr && !serial_cs_n;
    assign acc_rd = rd && !serial_cs_n;

    // ==========================================
    // Strap capture after reset release
    logic strap_taken;
    logic next_strap_taken;
    logic strap_load;

    assign strap_load = !strap_taken;

    always_comb begin
        next_strap_taken = 1'b1;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            strap_taken <= 1'b0;
        end else begin
            strap_taken <= next_strap_taken;
        end
    end

    // ==========================================
    // Control register
    rfs_ctrl_t ctrl;
    rfs_ctrl_t next_ctrl;

    always_comb begin
        next_ctrl = ctrl;
        if (strap_load) begin
            next_ctrl.synth_src = strap_reader_first[`RFS_STRAP_SYNTH_BIT];
        end else if (acc_wr && addr == `RFS_CTRL_ADDR) begin
            next_ctrl.soft_sel = wdata[`RFS_CTRL_SOFT_SEL_BIT];
            next_ctrl.soft_en = wdata[`RFS_CTRL_SOFT_EN_BIT];
            next_ctrl.auto_en = wdata[`RFS_CTRL_AUTO_EN_BIT];
            next_ctrl.synth_src = wdata[`RFS_CTRL_SYNTH_SRC_BIT];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl <= '0;
        end else begin
            ctrl <= next_ctrl;
        end
    end

    // ==========================================
    // Receiver format registers
    rfs_fmt_t [`RFS_NUM_RX-1:0] fmt;
    rfs_fmt_t [`RFS_NUM_RX-1:0] next_fmt;
    logic [`RFS_ADDR_W-1:0] fmt_addr [`RFS_NUM_RX];

    assign fmt_addr[0] = `RFS_FMT_A_ADDR;
    assign fmt_addr[1] = `RFS_FMT_B_ADDR;
    assign fmt_addr[2] = `RFS_FMT_M_ADDR;

    genvar gi;
    generate
        for (gi = 0; gi < `RFS_NUM_RX; gi++) begin : g_fmt
            always_comb begin
                next_fmt[gi] = fmt[gi];
                if (strap_load) begin
                    next_fmt[gi] = strap_reader_first[gi*`RFS_FMT_W +: `RFS_FMT_W];
                end else if (acc_wr && addr == fmt_addr[gi]) begin
                    next_fmt[gi] = wdata[`RFS_FMT_W-1:0];
                end
            end

            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    fmt[gi] <= '0;
                end else begin
                    fmt[gi] <= next_fmt[gi];
                end
            end
        end
    endgenerate

    assign receiver_format = fmt;

    // ==========================================
    // Selection source
    logic auto_sel;
    logic next_auto_sel;
    logic want_sel;

    always_comb begin
        next_auto_sel = auto_sel;
        if (mon.ref_a_lost && !mon.ref_b_lost) begin
            next_auto_sel = 1'b1;
        end else if (mon.ref_b_lost && !mon.ref_a_lost) begin
            next_auto_sel = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            auto_sel <= 1'b0;
        end else begin
            auto_sel <= next_auto_sel;
        end
    end

    always_comb begin
        if (ctrl.auto_en) begin
            want_sel = auto_sel;
        end else if (ctrl.soft_en) begin
            want_sel = ctrl.soft_sel;
        end else begin
            want_sel = reference_select;
        end
    end

    // ==========================================
    // Switchover sequencer and mux
    rfs_sw_stat_t sw;

    rfs_switch_seq u_seq (
        .clk(clk),
        .nrst(nrst),
        .want_sel(want_sel),
        .reference_input_a(reference_input_a),
        .reference_input_b(reference_input_b),
        .selected_reference(selected_reference),
        .stat(sw)
    );

    // ==========================================
    // Status pins and third reference routing
    logic next_active;
    logic next_switching;
    logic next_mon_out;
    logic next_synth_ref;

    always_comb begin
        next_active = sw.active;
        next_switching = sw.switching;
        next_mon_out = monitor_reference_input;
        next_synth_ref = ctrl.synth_src ? selected_reference : monitor_reference_input;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            active_reference_indicator <= 1'b0;
            switchover_in_progress <= 1'b0;
            monitor_reference_out <= 1'b0;
            integer_synth_loop_ref <= 1'b0;
        end else begin
            active_reference_indicator <= next_active;
            switchover_in_progress <= next_switching;
            monitor_reference_out <= next_mon_out;
            integer_synth_loop_ref <= next_synth_ref;
        end
    end

    // ==========================================
    // Interrupt status and mask
    logic [`RFS_IRQ_W-1:0] irq_stat;
    logic [`RFS_IRQ_W-1:0] next_irq_stat;
    logic [`RFS_IRQ_W-1:0] irq_mask;
    logic [`RFS_IRQ_W-1:0] next_irq_mask;
    logic [`RFS_IRQ_W-1:0] irq_set;
    logic [`RFS_IRQ_W-1:0] irq_clr;

    always_comb begin
        irq_set = '0;
        irq_set[`RFS_IRQ_START_BIT] = sw.start;
        irq_set[`RFS_IRQ_DONE_BIT] = sw.done;
        irq_clr = '0;
        if (acc_wr && addr == `RFS_IRQ_STAT_ADDR) begin
            irq_clr = wdata[`RFS_IRQ_W-1:0];
        end
        // Set wins over a same-cycle clear
        next_irq_stat = (irq_stat & ~irq_clr) | irq_set;
        next_irq_mask = irq_mask;
        if (acc_wr && addr == `RFS_IRQ_MASK_ADDR) begin
            next_irq_mask = wdata[`RFS_IRQ_W-1:0];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq_stat <= '0;
            irq_mask <= '0;
        end else begin
            irq_stat <= next_irq_stat;
            irq_mask <= next_irq_mask;
        end
    end

    assign irq = |(irq_stat & irq_mask);

    // ==========================================
    // Read port
    logic [`RFS_DATA_W-1:0] next_rdata;

    always_comb begin
        next_rdata = '0;
        if (acc_rd) begin
            unique case (addr)
                `RFS_CTRL_ADDR: begin
                    next_rdata[`RFS_CTRL_SOFT_SEL_BIT] = ctrl.soft_sel;
                    next_rdata[`RFS_CTRL_SOFT_EN_BIT] = ctrl.soft_en;
                    next_rdata[`RFS_CTRL_AUTO_EN_BIT] = ctrl.auto_en;
                    next_rdata[`RFS_CTRL_SYNTH_SRC_BIT] = ctrl.synth_src;
                end
                `RFS_FMT_A_ADDR: begin
                    next_rdata[`RFS_FMT_W-1:0] = fmt[0];
                end
                `RFS_FMT_B_ADDR: begin
                    next_rdata[`RFS_FMT_W-1:0] = fmt[1];
                end
                `RFS_FMT_M_ADDR: begin
                    next_rdata[`RFS_FMT_W-1:0] = fmt[2];
                end
                `RFS_STATUS_ADDR: begin
                    next_rdata[`RFS_STAT_ACTIVE_BIT] = sw.active;
                    next_rdata[`RFS_STAT_SWITCHING_BIT] = sw.switching;
                end
                `RFS_IRQ_STAT_ADDR: begin
                    next_rdata[`RFS_IRQ_W-1:0] = irq_stat;
                end
                `RFS_IRQ_MASK_ADDR: begin
                    next_rdata[`RFS_IRQ_W-1:0] = irq_mask;
                end
                default: begin
                    next_rdata = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata <= '0;
        end else begin
            rdata <= next_rdata;
        end
    end

endmodule

// >>> testbench/rfs_host_model.sv
`timescale 1ns/1ns

// ==========================================
// Board-side references and serial host
module rfs_host_model (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Bench request to program
    input wire logic prog,
    // Chip select and references
    output logic serial_cs_n,
    output logic reference_input_a,
    output logic reference_input_b,
    output logic monitor_reference_input
);
    logic [2:0] ph;

    // Chip select low for the whole programming session
    assign serial_cs_n = ~prog;

    // Three distinct reference patterns
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ph <= 3'h0;
        end else begin
            ph <= ph + 3'h1;
        end
    end
    assign reference_input_a = ph[0];
    assign reference_input_b = ph[1];
    assign monitor_reference_input = ph[2] ^ ph[0];
endmodule

// >>> testbench/rfs_ref_select_chk.sv
`timescale 1ns/1ns
`include "rfs_regs.svh"

module rfs_ref_select_chk
    import rfs_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Register port
    input wire logic rd,
    input wire logic serial_cs_n,
    input wire logic [`RFS_DATA_W-1:0] rdata,
    // References and straps
    input wire logic reference_input_a,
    input wire logic reference_input_b,
    input wire logic monitor_reference_input,
    input wire logic [`RFS_STRAP_W-1:0] strap_reader_first,
    // Outputs watched
    input wire logic selected_reference,
    input wire logic monitor_reference_out,
    input wire logic integer_synth_loop_ref,
    input wire logic active_reference_indicator,
    input wire logic switchover_in_progress,
    input wire rfs_fmt_t [`RFS_NUM_RX-1:0] receiver_format
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // ==========================================
    // Length of a switch in cycles
    logic [4:0] sw_cnt;
    logic [4:0] next_sw_cnt;
    always_comb begin
        next_sw_cnt = switchover_in_progress ? sw_cnt + 5'h01 : 5'h00;
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sw_cnt <= 5'h00;
        end else begin
            sw_cnt <= next_sw_cnt;
        end
    end

    // ==========================================
    // Properties
    AST_MUX_A: assert property ($past(nrst) && !switchover_in_progress && !active_reference_indicator
        |-> selected_reference == $past(reference_input_a)) else $error("mux output not reference a");
    AST_MUX_B: assert property ($past(nrst) && !switchover_in_progress && active_reference_indicator
        |-> selected_reference == $past(reference_input_b)) else $error("mux output not reference b");
    AST_ACT_FLIP: assert property ($rose(switchover_in_progress)
        |-> ##5 $changed(active_reference_indicator)) else $error("active indicator flip misplaced");
    AST_ACT_HOLD: assert property ($past(nrst) && !switchover_in_progress && !$past(switchover_in_progress)
        |-> $stable(active_reference_indicator)) else $error("active indicator moved outside switch");
    AST_SW_LEN: assert property ($fell(switchover_in_progress) |-> sw_cnt == 5'd15)
        else $error("switch indicator length wrong");
    AST_BREAK: assert property ($rose(switchover_in_progress) |-> !selected_reference [*5])
        else $error("mux output not quiet in break");
    AST_RD_QUIET: assert property (!($past(rd) && !$past(serial_cs_n)) |-> rdata == 8'h00)
        else $error("read data outside read slot");
    AST_FMT_STRAP: assert property ($rose(nrst) |=> receiver_format == strap_reader_first[5:0])
        else $error("formats not strapped");
    AST_MON: assert property ($past(nrst) |-> monitor_reference_out == $past(monitor_reference_input))
        else $error("monitor reference not passed");
    AST_SYNTH: assert property ($past(nrst) |-> integer_synth_loop_ref == $past(monitor_reference_input)
        || integer_synth_loop_ref == $past(selected_reference)) else $error("synth reference source wrong");
endmodule

bind rfs_ref_select rfs_ref_select_chk chk (.clk, .nrst, .rd, .serial_cs_n, .rdata, .reference_input_a,
    .reference_input_b, .monitor_reference_input, .strap_reader_first, .selected_reference,
    .monitor_reference_out, .integer_synth_loop_ref, .active_reference_indicator, .switchover_in_progress,
    .receiver_format);

// >>> testbench/tb_reference_input_selector.sv
`timescale 1ns/1ns
`include "rfs_regs.svh"

module tb_reference_input_selector;
    import rfs_pkg::*;
    logic clk, nrst, wr, rd, prog, cs_n, ra, rb, rm, sel, irq, act, sw, sref, mref, iref;
    logic [11:0] addr;
    logic [7:0] wdata, rdata;
    rfs_mon_t mon;
    rfs_fmt_t [2:0] fmt;
    int err_count, checked, cyc;

    rfs_host_model host (.clk(clk), .nrst(nrst), .prog(prog), .serial_cs_n(cs_n),
        .reference_input_a(ra), .reference_input_b(rb), .monitor_reference_input(rm));
    rfs_ref_select uut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .serial_cs_n(cs_n), .reference_input_a(ra), .reference_input_b(rb),
        .monitor_reference_input(rm), .reference_select(sel), .mon(mon), .strap_reader_first(7'h5b),
        .selected_reference(sref), .monitor_reference_out(mref), .integer_synth_loop_ref(iref),
        .active_reference_indicator(act), .switchover_in_progress(sw), .receiver_format(fmt), .irq(irq));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // ==========================================
    // Shared tasks
    task chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task wr_reg(input logic [11:0] a, input logic [7:0] v);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task rd_reg(input logic [11:0] a, input logic [7:0] exp);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        chk(rdata, exp);
    endtask
    task wait_sw(input logic lvl);
        int n;
        n = 0;
        while (sw !== lvl && n < 40) begin
            @(posedge clk);
            n++;
        end
        chk({7'h0, sw}, {7'h0, lvl});
    endtask
    task end_of_test;
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ==========================================
    // Scenarios
    task t_straps;
        rd_reg(12'h083, 8'h03);
        rd_reg(12'h084, 8'h02);
        rd_reg(12'h085, 8'h01);
        rd_reg(12'h082, 8'h08);
        wr_reg(12'h084, 8'h01);
        rd_reg(12'h084, 8'h01);
        chk({2'h0, fmt}, 8'h17);
        $display("test straps done");
    endtask
    task t_pin;
        sel <= 1'b1;
        wait_sw(1'b1);
        wait_sw(1'b0);
        chk({7'h0, act}, 8'h01);
        rd_reg(12'h086, 8'h01);
        rd_reg(12'h087, 8'h03);
        chk({7'h0, irq}, 8'h00);
        wr_reg(12'h088, 8'h02);
        chk({7'h0, irq}, 8'h01);
        wr_reg(12'h087, 8'h02);
        chk({7'h0, irq}, 8'h00);
        rd_reg(12'h087, 8'h01);
        $display("test pin done");
    endtask
    task t_modes;
        wr_reg(12'h082, 8'h0b);
        sel <= 1'b0;
        repeat (20) @(posedge clk);
        chk({7'h0, act}, 8'h01);
        wr_reg(12'h082, 8'h0a);
        wait_sw(1'b1);
        wait_sw(1'b0);
        chk({7'h0, act}, 8'h00);
        wr_reg(12'h082, 8'h0c);
        mon.ref_a_lost <= 1'b1;
        wait_sw(1'b1);
        wait_sw(1'b0);
        chk({7'h0, act}, 8'h01);
        // Reference b lost: automatic selection falls back to a
        mon <= 2'b01;
        wait_sw(1'b1);
        wait_sw(1'b0);
        chk({7'h0, act}, 8'h00);
        mon <= 2'b00;
        sel <= 1'b1;
        wr_reg(12'h082, 8'h08);
        wait_sw(1'b1);
        wait_sw(1'b0);
        chk({7'h0, act}, 8'h01);
        $display("test modes done");
    endtask
    task t_synth;
        logic pm, pb, pb2;
        // Synth loop fed from the monitor reference
        wr_reg(12'h082, 8'h00);
        @(posedge clk);
        pm = rm;
        pb = rb;
        repeat (4) begin
            @(posedge clk);
            chk({7'h0, iref}, {7'h0, pm});
            chk({7'h0, mref}, {7'h0, pm});
            chk({7'h0, sref}, {7'h0, pb});
            pm = rm;
            pb = rb;
        end
        // Synth loop fed from the selector output, one more stage
        wr_reg(12'h082, 8'h08);
        pb = rb;
        @(posedge clk);
        pb2 = pb;
        pb = rb;
        repeat (4) begin
            @(posedge clk);
            chk({7'h0, iref}, {7'h0, pb2});
            pb2 = pb;
            pb = rb;
        end
        $display("test synth source done");
    endtask
    task t_cs;
        prog <= 1'b0;
        wr_reg(12'h082, 8'h0a);
        rd_reg(12'h082, 8'h00);
        repeat (20) @(posedge clk);
        chk({7'h0, act}, 8'h01);
        prog <= 1'b1;
        rd_reg(12'h0ff, 8'h00);
        rd_reg(12'h082, 8'h08);
        $display("test chip select done");
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            end_of_test;
        end
    end

    initial begin
        nrst = 1'b0;
        {wr, rd, sel, addr, wdata} = '0;
        mon = '0;
        prog = 1'b1;
        err_count = 0;
        checked = 0;
        cyc = 0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
        t_straps;
        t_pin;
        t_modes;
        t_synth;
        t_cs;
        end_of_test;
    end
endmodule
